// [rtl/uar_defines.svh]
// Register offsets, field positions, reset values and timing counts of the receiver
`ifndef UAR_DEFINES_SVH
`define UAR_DEFINES_SVH
`define UAR_OFF_FLAGS 8'h0C
`define UAR_OFF_RXCTL 8'h18
`define UAR_OFF_TXDATA 8'h19
`define UAR_OFF_RXDATA 8'h1A
`define UAR_OFF_ENABLES 8'h8C
`define UAR_OFF_TXCTL 8'h98
`define UAR_OFF_BAUD 8'h99
`define UAR_RST_FLAGS 8'h00
`define UAR_RST_RXCTL 8'h00
`define UAR_RST_ENABLES 8'h00
`define UAR_RST_TXCTL 8'h02
`define UAR_RST_BAUD 8'h00
`define UAR_RST_TXDATA 8'h00
`define UAR_RST_RXDATA 8'h00
`define UAR_FLG_PARALLEL 7
`define UAR_FLG_RECEIVE 5
`define UAR_FLG_TXEMPTY 4
`define UAR_RC_SERIAL_PORT_ENABLE 7
`define UAR_RC_RX9 6
`define UAR_RC_SINGLE_RECEIVE_ENABLE 5
`define UAR_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define UAR_RC_ADDRESS_DETECT_ENABLE 3
`define UAR_RC_FRAMING_ERROR 2
`define UAR_RC_OVERRUN_ERROR 1
`define UAR_RC_RECEIVED_NINTH_BIT 0
`define UAR_TC_CLOCK_SOURCE_MASTER_SELECT 7
`define UAR_TC_TX9 6
`define UAR_TC_TRANSMIT_ENABLE 5
`define UAR_TC_SYNC 4
`define UAR_TC_UNUSED 3
`define UAR_TC_HIGH_SPEED_BAUD_SELECT 2
`define UAR_TC_TRANSMIT_SHIFTER_EMPTY 1
`define UAR_TC_TRANSMIT_NINTH_BIT 0
`define UAR_OVS 16
`define UAR_OVS_MID 4'h7
`define UAR_OVS_LAST 4'hF
`endif

// [rtl/uar_pkg.sv]
// Types shared by the receiver
package uar_pkg;
    typedef enum logic [1:0] {UAR_IDLE, UAR_START, UAR_DATA, UAR_STOP} uar_state_type;
    typedef struct packed {
        logic [8:0] bits;
        logic stop_ok;
    } uar_frame_type;
endpackage : uar_pkg

// [rtl/uar_rx.sv]
// Asynchronous receiver with nine-bit address detect and Wishbone register file
//
// Overview of operation
// - Oversample the receive pin at sixteen times the bit rate.
// - Nine-bit enable receives nine data bits; ninth lands in status bit 0.
// - With address detect, raise receive event only when ninth bit is one.
// - Ninth bit one marks an address byte, zero a data byte.
// - Address byte with detect enabled loads buffer and raises event.
// - Data byte under address detect loads nothing and raises nothing.
// - A suppressed data byte is simply overwritten by the next frame.
// - Address detect acts only in nine-bit asynchronous mode.
// - Reception begins only once continuous receive enable is set.
// - Completed reception sets receive flag; request only if enabled.
// - Clearing continuous receive enable clears latched errors.
// - Synchronous master mode is half duplex.
// - Synchronous mode selected when transmit control bit 4 is set.
// - Serial port enable hands the pins to the serial functions.
// - Clock source select makes the device master driving the clock.
// - Unimplemented transmit control bit reads as zero.
// - Frame is one start bit, eight or nine data bits, one stop bit.
// - Data bits travel least significant first.
// - Asynchronous mode selected when transmit control bit 4 is clear.
// - Asynchronous activity stops while the core sleeps.
`timescale 1ns/1ps
`include "uar_defines.svh"
module uar_rx
    import uar_pkg::*;
#(
    parameter int OVS_BITS = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core state
    input wire logic core_sleep,
    input wire logic tx_busy,
    // Serial pins
    input wire logic receive_data_pin,
    output logic pins_serial_r,
    output logic shift_clock_master_r,
    // Receive request
    output logic rx_irq_r
);
    // Timing of a bus access
    // A request is taken on the edge where cyc and stb are high and ack is low.
    // Ack rises on that same edge and stands for exactly one cycle.
    // Read data is registered together with ack, so it stands with it.
    // Gating the take with ack stops a held request acting twice.
    // A master must drop cyc for a cycle before its next request.
    // Writes need sel bit 0; the other lanes carry nothing.
    // Unmapped offsets are still acked so a master never hangs.
    // Unmapped reads return zero, unmapped writes change nothing.
    //
    // Timing of the oversample tick
    // The divisor counter wraps after divisor plus one cycles.
    // With high speed off, only every fourth wrap makes a tick.
    // The counter is held clear while the receiver is stopped.
    // Restart begins a fresh tick period only with high speed on; the divide-by-four count is not cleared.
    // Sixteen ticks make one bit time on the line.
    //
    // Timing of a frame
    // The pin passes two flops first; the frame lags the line by two cycles.
    // A low level seen on a tick while idle starts the start-bit count.
    // Eight ticks later the start bit is checked again near its middle.
    // A high level there is taken as a glitch and the frame is dropped.
    // Each data bit is then sampled sixteen ticks after the previous one.
    // Bits enter from the top of the shifter, so the first lands lowest.
    // In eight-bit mode the ninth position is held at zero.
    // The stop bit is sampled once, near its middle, like the data.
    // The done pulse follows that sample and lasts one cycle.
    //
    // Completion
    // Done with delivery updates the ninth bit and the error bits.
    // The data byte is loaded only when the buffer has been read.
    // An overrun keeps the older byte; the newer one is lost.
    // The receive flag follows one cycle after done.
    // The request output follows the flag by one more cycle.
    // Reading the data buffer clears the unread mark at the take.
    // The flag then falls on the next edge and the request after it.
    //
    // Address detect
    // Detect is honoured only with nine-bit receive in asynchronous mode.
    // A frame with ninth bit zero is then dropped without any trace.
    // Neither the buffer, the flag nor the status bits change for it.
    // The shifter simply takes the next frame over the dropped one.
    // Software clears detect once it has seen its own address.
    //
    // Error bits
    // Framing and overrun indications are set only by hardware.
    // Writing the control register with continuous receive off clears them.
    // A completion in the same cycle as that write wins over the clear.
    // This keeps an error from vanishing unseen between two reads.
    //
    // Mode and pins
    // Setting the sync bit stops the asynchronous receiver outright.
    // Sleep stops it too; a frame in flight is abandoned.
    // The pin handover output mirrors the serial port enable.
    // The clock drive output needs port enable, sync and master select.
    // In sync mode a busy transmitter also holds the receiver idle.
    // Limitation: no synchronous shifting lives in this block.
    // Limitation: single receive enable is stored but has no effect.
    // The transmit status shifter-empty bit always reads one here.

    // Registers
    logic [7:0] flags_r;
    logic [7:0] enables_r;
    logic [7:0] rxctl_r;
    logic [7:0] txctl_r;
    logic [7:0] baud_r;
    logic [7:0] txdata_r;
    logic [7:0] rxdata_r;
    logic [7:0] rd_nxt;
    logic sync_a_r;
    logic sync_b_r;
    logic [7:0] brg_cnt_r;
    logic tick_r;
    logic [1:0] pre_cnt_r;
    uar_state_type state_r;
    logic [OVS_BITS-1:0] ovs_r;
    logic [3:0] bit_cnt_r;
    uar_frame_type frame_r;
    logic done_r;
    logic unread_r;
    logic bus_hit;
    logic wr_en;
    logic rd_en;
    logic async_run;
    logic detect_on;
    logic deliver;
    logic [3:0] last_bit;

    // Decode a byte address to a mapped register
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `UAR_OFF_FLAGS) || (a == `UAR_OFF_RXCTL) ||
            (a == `UAR_OFF_TXDATA) || (a == `UAR_OFF_RXDATA) ||
            (a == `UAR_OFF_ENABLES) || (a == `UAR_OFF_TXCTL) || (a == `UAR_OFF_BAUD);
    endfunction : is_mapped

    // Bus strobes; ack lasts one cycle so each access acts once
    assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = bus_hit && wb_we_i && wb_sel_i[0];
    assign rd_en = bus_hit && !wb_we_i;

    // Asynchronous receive runs only with port on, async mode, receive on, awake
    assign async_run = rxctl_r[`UAR_RC_SERIAL_PORT_ENABLE] && !txctl_r[`UAR_TC_SYNC] &&
        rxctl_r[`UAR_RC_CONTINUOUS_RECEIVE_ENABLE] && !core_sleep;
    // Detect honoured only in nine-bit asynchronous mode
    assign detect_on = rxctl_r[`UAR_RC_ADDRESS_DETECT_ENABLE] && rxctl_r[`UAR_RC_RX9] &&
        !txctl_r[`UAR_TC_SYNC];
    // Ninth bit one is an address; data bytes are dropped under detect
    assign deliver = !detect_on || frame_r.bits[8];
    assign last_bit = rxctl_r[`UAR_RC_RX9] ? 4'h8 : 4'h7;

    // Ack and read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_hit;
            wb_dat_o <= {24'h000000, rd_nxt};
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_nxt = 8'h00;
        case (wb_adr_i)
            `UAR_OFF_FLAGS: rd_nxt = flags_r;
            `UAR_OFF_RXCTL: rd_nxt = rxctl_r;
            `UAR_OFF_TXDATA: rd_nxt = txdata_r;
            `UAR_OFF_RXDATA: rd_nxt = rxdata_r;
            `UAR_OFF_ENABLES: rd_nxt = enables_r;
            `UAR_OFF_TXCTL: rd_nxt = txctl_r & 8'hF7;
            `UAR_OFF_BAUD: rd_nxt = baud_r;
            default: rd_nxt = 8'h00;
        endcase
        if (!is_mapped(wb_adr_i)) begin
            rd_nxt = 8'h00;
        end
    end

    // Plain software registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enables_r <= `UAR_RST_ENABLES;
            txctl_r <= `UAR_RST_TXCTL;
            baud_r <= `UAR_RST_BAUD;
            txdata_r <= `UAR_RST_TXDATA;
        end else if (wr_en) begin
            case (wb_adr_i)
                `UAR_OFF_ENABLES: enables_r <= wb_dat_i[7:0];
                // Shifter-empty stays set: no transmitter here
                `UAR_OFF_TXCTL: txctl_r <= (wb_dat_i[7:0] & 8'hF5) | 8'h02;
                `UAR_OFF_BAUD: baud_r <= wb_dat_i[7:0];
                `UAR_OFF_TXDATA: txdata_r <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Receive control and status; error bits and ninth bit are hardware owned
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxctl_r <= `UAR_RST_RXCTL;
        end else begin
            if (wr_en && wb_adr_i == `UAR_OFF_RXCTL) begin
                rxctl_r[7:3] <= wb_dat_i[7:3];
                if (!wb_dat_i[`UAR_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
                    rxctl_r[`UAR_RC_FRAMING_ERROR] <= 1'b0;
                    rxctl_r[`UAR_RC_OVERRUN_ERROR] <= 1'b0;
                end
            end
            // Completion wins over a same-cycle clear
            if (done_r && deliver) begin
                rxctl_r[`UAR_RC_RECEIVED_NINTH_BIT] <= frame_r.bits[8];
                if (!frame_r.stop_ok) begin
                    rxctl_r[`UAR_RC_FRAMING_ERROR] <= 1'b1;
                end
                if (unread_r) begin
                    rxctl_r[`UAR_RC_OVERRUN_ERROR] <= 1'b1;
                end
            end
        end
    end

    // Receive buffer and unread tracking; an overrun keeps the old byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxdata_r <= `UAR_RST_RXDATA;
            unread_r <= 1'b0;
        end else if (done_r && deliver && !unread_r) begin
            rxdata_r <= frame_r.bits[7:0];
            unread_r <= 1'b1;
        end else if (rd_en && wb_adr_i == `UAR_OFF_RXDATA) begin
            unread_r <= 1'b0;
        end
    end

    // Event flags; receive flag mirrors unread data, transmit empty flag mirrors transmit enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flags_r <= `UAR_RST_FLAGS;
        end else begin
            if (wr_en && wb_adr_i == `UAR_OFF_FLAGS) begin
                flags_r[7:6] <= wb_dat_i[7:6];
                flags_r[3:0] <= wb_dat_i[3:0];
            end
            flags_r[`UAR_FLG_RECEIVE] <= unread_r || (done_r && deliver);
            flags_r[`UAR_FLG_TXEMPTY] <= txctl_r[`UAR_TC_TRANSMIT_ENABLE];
        end
    end

    // Request output gated by the receive enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_irq_r <= 1'b0;
        end else begin
            rx_irq_r <= flags_r[`UAR_FLG_RECEIVE] && enables_r[`UAR_FLG_RECEIVE];
        end
    end

    // Pin takeover and master clock drive outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pins_serial_r <= 1'b0;
            shift_clock_master_r <= 1'b0;
        end else begin
            pins_serial_r <= rxctl_r[`UAR_RC_SERIAL_PORT_ENABLE];
            shift_clock_master_r <= rxctl_r[`UAR_RC_SERIAL_PORT_ENABLE] && txctl_r[`UAR_TC_SYNC] &&
                txctl_r[`UAR_TC_CLOCK_SOURCE_MASTER_SELECT];
        end
    end

    // Pin synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_a_r <= 1'b1;
            sync_b_r <= 1'b1;
        end else begin
            sync_a_r <= receive_data_pin;
            sync_b_r <= sync_a_r;
        end
    end

    // Oversample tick: divisor+1 cycles, slowed fourfold unless high speed
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            brg_cnt_r <= 8'h00;
            pre_cnt_r <= 2'h0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (!async_run || brg_cnt_r >= baud_r) begin
                brg_cnt_r <= 8'h00;
                if (async_run) begin
                    pre_cnt_r <= pre_cnt_r + 2'h1;
                    tick_r <= txctl_r[`UAR_TC_HIGH_SPEED_BAUD_SELECT] || (pre_cnt_r == 2'h3);
                end
            end else begin
                brg_cnt_r <= brg_cnt_r + 8'h01;
            end
        end
    end

    // Frame recovery at sixteen ticks per bit, sampled mid-bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= UAR_IDLE;
            ovs_r <= '0;
            bit_cnt_r <= 4'h0;
            frame_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            // Half duplex: synchronous mode with transmit busy holds off
            if (!async_run || (txctl_r[`UAR_TC_SYNC] && tx_busy)) begin
                state_r <= UAR_IDLE;
            end else if (tick_r) begin
                ovs_r <= ovs_r + 1'b1;
                case (state_r)
                    UAR_IDLE: begin
                        ovs_r <= '0;
                        if (!sync_b_r) begin
                            state_r <= UAR_START;
                        end
                    end
                    UAR_START: begin
                        if (ovs_r == OVS_BITS'(`UAR_OVS_MID)) begin
                            ovs_r <= '0;
                            bit_cnt_r <= 4'h0;
                            // Glitch rejection: start must still be low mid-bit
                            state_r <= sync_b_r ? UAR_IDLE : UAR_DATA;
                        end
                    end
                    UAR_DATA: begin
                        if (ovs_r == OVS_BITS'(`UAR_OVS_LAST)) begin
                            // Shift in from the top, least significant first
                            if (rxctl_r[`UAR_RC_RX9]) begin
                                frame_r.bits <= {sync_b_r, frame_r.bits[8:1]};
                            end else begin
                                frame_r.bits <= {1'b0, sync_b_r, frame_r.bits[7:1]};
                            end
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == last_bit) begin
                                state_r <= UAR_STOP;
                            end
                        end
                    end
                    UAR_STOP: begin
                        if (ovs_r == OVS_BITS'(`UAR_OVS_LAST)) begin
                            // Suppressed frames are dropped here and overwritten next
                            frame_r.stop_ok <= sync_b_r;
                            done_r <= 1'b1;
                            state_r <= UAR_IDLE;
                        end
                    end
                    default: state_r <= UAR_IDLE;
                endcase
            end
        end
    end
endmodule : uar_rx

// [test/uar_peer_tx.sv]
// Far-side serial transmitter that sends one asynchronous frame per request
`timescale 1ns/1ps
module uar_peer_tx #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input wire logic ref_clk,
    // Frame request
    input wire logic go,
    input wire logic [8:0] word,
    input wire logic nine,
    input wire logic stop_bit,
    // Serial line and status
    output logic line,
    output logic busy
);
    // The line idles high, so the receiver never sees a false start between frames
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    // Start bit, data bits, optional ninth bit, then a stop bit that may be forced low
    always @(posedge ref_clk) begin
        if (go) begin
            busy <= 1'b1;
            line <= 1'b0;
            repeat (BIT_CYC) @(posedge ref_clk);
            for (int i = 0; i < 9; i++) begin
                if (i < 8 || nine) begin
                    line <= word[i];
                    repeat (BIT_CYC) @(posedge ref_clk);
                end
            end
            line <= stop_bit;
            repeat (BIT_CYC) @(posedge ref_clk);
            line <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule : uar_peer_tx

// [test/uar_rx_properties.sv]
// Port-level checker for the receiver and its register bus
`timescale 1ns/1ps
`include "uar_defines.svh"
module uar_rx_properties #(
    parameter int OVS_BITS = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Outputs
    input wire logic pins_serial_r,
    input wire logic shift_clock_master_r,
    input wire logic rx_irq_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Read acknowledge seen on each register
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;
    ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("acknowledge without request");
    upper_zero_a: assert property (rd_ack |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    unmapped_zero_a: assert property (rd_ack && !(wb_adr_i inside {8'h0C, 8'h18, 8'h19,
        8'h1A, 8'h8C, 8'h98, 8'h99}) |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    unused_bit_a: assert property (rd_ack && wb_adr_i == `UAR_OFF_TXCTL |-> !wb_dat_o[3])
        else $error("unimplemented bit reads one");
    pin_handover_a: assert property (rd_ack && wb_adr_i == `UAR_OFF_RXCTL |->
        wb_dat_o[7] == pins_serial_r)
        else $error("pin handover differs from port enable");
    clock_master_a: assert property (rd_ack && wb_adr_i == `UAR_OFF_TXCTL |->
        shift_clock_master_r == (pins_serial_r && wb_dat_o[7] && wb_dat_o[4]))
        else $error("clock master output wrong");
    irq_flag_a: assert property (rd_ack && wb_adr_i == `UAR_OFF_FLAGS && rx_irq_r |->
        wb_dat_o[5])
        else $error("request without receive flag");
endmodule : uar_rx_properties
bind uar_rx uar_rx_properties #(.OVS_BITS(OVS_BITS)) u_props (.ref_clk(ref_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_serial_r(pins_serial_r),
    .shift_clock_master_r(shift_clock_master_r), .rx_irq_r(rx_irq_r));

// [test/uar_rx_tb.sv]
// Self-checking bench: register access and frame reception with address detect
`timescale 1ns/1ps
`include "uar_defines.svh"
module uar_rx_tb;
    logic ref_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
    logic wb_ack_o, core_sleep = 1'b0, tx_busy = 1'b0, line, busy, go = 1'b0, nine = 1'b0;
    logic stop_bit = 1'b1, pins_serial_r, shift_clock_master_r, rx_irq_r;
    logic [8:0] word = 9'h000;
    logic [7:0] q;
    int errors = 0, checks_done = 0;
    logic [7:0] offs [7] = '{8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99};
    logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    uar_rx dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_sleep(core_sleep), .tx_busy(tx_busy),
        .receive_data_pin(line), .pins_serial_r(pins_serial_r),
        .shift_clock_master_r(shift_clock_master_r), .rx_irq_r(rx_irq_r));
    // Divisor 0 with high speed select gives sixteen clocks per bit
    uar_peer_tx #(.BIT_CYC(16)) peer (.ref_clk(ref_clk), .go(go), .word(word), .nine(nine),
        .stop_bit(stop_bit), .line(line), .busy(busy));
    // 10 MHz clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic wrap_up;
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One classic cycle; request held until the edge that samples ack high
    task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge ref_clk);
    endtask : xfer
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(nm, e, q & m);
    endtask : rd
    // Hand one frame to the far side and wait until its stop bit has gone out
    task automatic send(input logic [8:0] w, input logic n, input logic s);
        word <= w;
        nine <= n;
        stop_bit <= s;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        @(posedge ref_clk);
        while (busy) @(posedge ref_clk);
        repeat (6) @(posedge ref_clk);
    endtask : send
    // Watchdog sized well above the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 7; i++) rd("reset value", offs[i], 8'hFF, rstv[i]);
        rd("unmapped", 8'h55, 8'hFF, 8'h00);
        xfer(1'b1, `UAR_OFF_BAUD, 8'h00);
        xfer(1'b1, `UAR_OFF_TXCTL, 8'h04);
        xfer(1'b1, `UAR_OFF_RXCTL, 8'h80);
        xfer(1'b1, `UAR_OFF_ENABLES, 8'h20);
        chk("pins", 8'h01, {7'h00, pins_serial_r});
        send(9'h0C3, 1'b0, 1'b1);
        rd("flag idle", `UAR_OFF_FLAGS, 8'h20, 8'h00);
        xfer(1'b1, `UAR_OFF_RXCTL, 8'hD8);
        send(9'h0A5, 1'b1, 1'b1);
        rd("data dropped", `UAR_OFF_FLAGS, 8'h20, 8'h00);
        send(9'h13C, 1'b1, 1'b1);
        rd("addr flag", `UAR_OFF_FLAGS, 8'h20, 8'h20);
        chk("irq", 8'h01, {7'h00, rx_irq_r});
        rd("ninth bit", `UAR_OFF_RXCTL, 8'h01, 8'h01);
        rd("addr byte", `UAR_OFF_RXDATA, 8'hFF, 8'h3C);
        rd("flag cleared", `UAR_OFF_FLAGS, 8'h20, 8'h00);
        xfer(1'b1, `UAR_OFF_RXCTL, 8'hD0);
        send(9'h05A, 1'b1, 1'b1);
        rd("ninth zero", `UAR_OFF_RXCTL, 8'h01, 8'h00);
        rd("data byte", `UAR_OFF_RXDATA, 8'hFF, 8'h5A);
        xfer(1'b1, `UAR_OFF_RXCTL, 8'h98);
        send(9'h081, 1'b0, 1'b1);
        rd("detect ignored", `UAR_OFF_RXDATA, 8'hFF, 8'h81);
        xfer(1'b1, `UAR_OFF_RXCTL, 8'h90);
        send(9'h011, 1'b0, 1'b1);
        send(9'h022, 1'b0, 1'b0);
        rd("errors", `UAR_OFF_RXCTL, 8'h06, 8'h06);
        rd("kept byte", `UAR_OFF_RXDATA, 8'hFF, 8'h11);
        xfer(1'b1, `UAR_OFF_RXCTL, 8'h80);
        rd("errors cleared", `UAR_OFF_RXCTL, 8'h06, 8'h00);
        xfer(1'b1, `UAR_OFF_RXCTL, 8'h90);
        xfer(1'b1, `UAR_OFF_ENABLES, 8'h00);
        send(9'h044, 1'b0, 1'b1);
        rd("masked flag", `UAR_OFF_FLAGS, 8'h20, 8'h20);
        chk("masked irq", 8'h00, {7'h00, rx_irq_r});
        rd("masked byte", `UAR_OFF_RXDATA, 8'hFF, 8'h44);
        core_sleep <= 1'b1;
        send(9'h055, 1'b0, 1'b1);
        rd("sleep", `UAR_OFF_FLAGS, 8'h20, 8'h00);
        core_sleep <= 1'b0;
        tx_busy <= 1'b1;
        xfer(1'b1, `UAR_OFF_TXCTL, 8'h94);
        // Output registers one edge after the write lands; look once it has settled
        @(posedge ref_clk);
        chk("clock master", 8'h01, {7'h00, shift_clock_master_r});
        send(9'h066, 1'b0, 1'b1);
        rd("sync blocks", `UAR_OFF_FLAGS, 8'h20, 8'h00);
        rd("unused bit", `UAR_OFF_TXCTL, 8'h08, 8'h00);
        wrap_up();
    end
endmodule : uar_rx_tb
